// File: verilog/perf_monitor_pkg.sv
// Purpose: Shared constants and types for the performance monitor counters
// Assumes: Coprocessor style access selected by CRm and opcode_2 fields
// Notes: Register identifiers below are internal decode codes only
package perf_monitor_pkg;
  localparam int NUM_COUNTERS = 6;
  localparam int CNT_WIDTH = 32;
  localparam int NUM_EVENTS = 17;
  localparam int CYCLE_FLAG_BIT = 31;
  localparam int SELECT_WIDTH = 6;
  localparam int EVENT_CODE_WIDTH = 8;
  // Register transfer codes
  localparam logic [3:0] CRM_CONTROL_GROUP = 4'hC;
  localparam logic [3:0] CRM_COUNT_GROUP = 4'hD;
  localparam logic [3:0] CRM_USER_GROUP = 4'hE;
  localparam logic [2:0] OPC_MONITOR_CONTROL = 3'h0;
  localparam logic [2:0] OPC_OVERFLOW_FLAGS = 3'h3;
  localparam logic [2:0] OPC_SW_INCREMENT = 3'h4;
  localparam logic [2:0] OPC_COUNTER_SELECT = 3'h5;
  localparam logic [2:0] OPC_CYCLE_TALLY = 3'h0;
  localparam logic [2:0] OPC_EVENT_TYPE = 3'h1;
  localparam logic [2:0] OPC_EVENT_COUNT = 3'h2;
  localparam logic [2:0] OPC_USER_ACCESS = 3'h0;
  localparam logic [2:0] OPC_IRQ_ENABLE_SET = 3'h1;
  localparam logic [2:0] OPC_IRQ_ENABLE_CLEAR = 3'h2;
  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_EVENT_RESET_BIT = 1;
  localparam int CTRL_CYCLE_RESET_BIT = 2;
  localparam int USER_ENABLE_BIT = 0;
  localparam logic [31:0] FLAG_MASK = 32'h8000003F;
  localparam logic [31:0] CTRL_READ_MASK = 32'h00000001;
  // Event codes
  localparam logic [7:0] EV_SW_INCREMENT = 8'h00;
  localparam logic [7:0] EV_UNUSED_LOW = 8'h08;
  localparam logic [7:0] EV_UNUSED_HIGH = 8'h0E;
  localparam logic [7:0] EV_LAST_CODE = 8'h10;
  // Reset values
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [7:0] EVENT_TYPE_RESET = 8'h00;
  localparam logic [5:0] SELECT_RESET = 6'h00;
  typedef enum logic [3:0] {
    REG_NONE = 4'b0000,
    REG_CONTROL = 4'b0001,
    REG_OVERFLOW = 4'b0010,
    REG_SW_INCREMENT = 4'b0011,
    REG_SELECT = 4'b0100,
    REG_CYCLE = 4'b0101,
    REG_EVENT_TYPE = 4'b0110,
    REG_EVENT_COUNT = 4'b0111,
    REG_USER_ACCESS = 4'b1000,
    REG_IRQ_SET = 4'b1001,
    REG_IRQ_CLEAR = 4'b1010
  } reg_id_t;
endpackage

// File: verilog/perf_monitor_counters.sv
// Purpose: Six event counters and a cycle counter with overflow flags
// Assumes: One request per cycle, answered one cycle later
// Notes: Registers are common to both security states
`timescale 1ns/1ps
module perf_monitor_counters #(
  parameter int NUM_CNT = perf_monitor_pkg::NUM_COUNTERS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register transfer port
  input wire logic REQ,
  input wire logic WRITE,
  input wire logic [3:0] CRM,
  input wire logic [2:0] OPC2,
  input wire logic USER_MODE,
  input wire logic [31:0] WDATA,
  output logic ACK,
  output logic UNDEF,
  output logic [31:0] RDATA,
  // Pipeline event pulses, bit n for event code n
  input wire logic [perf_monitor_pkg::NUM_EVENTS-1:0] EVENTS,
  // Interrupt request
  output logic IRQ_N
);

  function automatic logic event_hit(
    input logic [7:0] code,
    input logic [perf_monitor_pkg::NUM_EVENTS-1:0] ev
  );
    logic hit;
    hit = 1'b0;
    if (code == perf_monitor_pkg::EV_SW_INCREMENT)
      hit = 1'b0;
    else if (code == perf_monitor_pkg::EV_UNUSED_LOW)
      hit = 1'b0;
    else if (code == perf_monitor_pkg::EV_UNUSED_HIGH)
      hit = 1'b0;
    else if (code <= perf_monitor_pkg::EV_LAST_CODE)
      hit = ev[code[4:0]];
    return hit;
  endfunction

  perf_monitor_pkg::reg_id_t reg_id;
  logic user_enable;
  logic global_enable;
  logic [31:0] overflow_flags;
  logic [31:0] irq_enable;
  logic [5:0] counter_selector;
  logic [31:0] cycle_tally_value;
  logic [31:0] event_count [NUM_CNT];
  logic [7:0] event_type_select [NUM_CNT];
  logic access_ok;
  logic do_write;
  logic [NUM_CNT-1:0] swinc_bits;
  logic [NUM_CNT-1:0] wrap;
  logic cycle_wrap;
  logic sel_valid;
  logic [2:0] sel_index;
  logic next_user_enable;
  logic next_global_enable;
  logic [31:0] next_overflow_flags;
  logic [31:0] next_irq_enable;
  logic [5:0] next_counter_selector;
  logic [31:0] next_cycle_tally_value;
  logic next_ack;
  logic next_undef;
  logic [31:0] next_rdata;
  logic next_irq_n;

  // Address decode
  always_comb
  begin
    reg_id = perf_monitor_pkg::REG_NONE;
    unique case (CRM)
      perf_monitor_pkg::CRM_CONTROL_GROUP:
      begin
        if (OPC2 == perf_monitor_pkg::OPC_MONITOR_CONTROL)
          reg_id = perf_monitor_pkg::REG_CONTROL;
        else if (OPC2 == perf_monitor_pkg::OPC_OVERFLOW_FLAGS)
          reg_id = perf_monitor_pkg::REG_OVERFLOW;
        else if (OPC2 == perf_monitor_pkg::OPC_SW_INCREMENT)
          reg_id = perf_monitor_pkg::REG_SW_INCREMENT;
        else if (OPC2 == perf_monitor_pkg::OPC_COUNTER_SELECT)
          reg_id = perf_monitor_pkg::REG_SELECT;
      end
      perf_monitor_pkg::CRM_COUNT_GROUP:
      begin
        if (OPC2 == perf_monitor_pkg::OPC_CYCLE_TALLY)
          reg_id = perf_monitor_pkg::REG_CYCLE;
        else if (OPC2 == perf_monitor_pkg::OPC_EVENT_TYPE)
          reg_id = perf_monitor_pkg::REG_EVENT_TYPE;
        else if (OPC2 == perf_monitor_pkg::OPC_EVENT_COUNT)
          reg_id = perf_monitor_pkg::REG_EVENT_COUNT;
      end
      perf_monitor_pkg::CRM_USER_GROUP:
      begin
        if (OPC2 == perf_monitor_pkg::OPC_USER_ACCESS)
          reg_id = perf_monitor_pkg::REG_USER_ACCESS;
        else if (OPC2 == perf_monitor_pkg::OPC_IRQ_ENABLE_SET)
          reg_id = perf_monitor_pkg::REG_IRQ_SET;
        else if (OPC2 == perf_monitor_pkg::OPC_IRQ_ENABLE_CLEAR)
          reg_id = perf_monitor_pkg::REG_IRQ_CLEAR;
      end
      default:
        reg_id = perf_monitor_pkg::REG_NONE;
    endcase
  end

  // Access permission; unmapped codes are undefined
  always_comb
  begin
    access_ok = 1'b1;
    unique case (reg_id)
      perf_monitor_pkg::REG_NONE:
        access_ok = 1'b0;
      perf_monitor_pkg::REG_USER_ACCESS:
        access_ok = !(USER_MODE && WRITE);
      // Interrupt controls stay privileged even with user enable set
      perf_monitor_pkg::REG_IRQ_SET, perf_monitor_pkg::REG_IRQ_CLEAR:
        access_ok = !USER_MODE;
      perf_monitor_pkg::REG_SW_INCREMENT:
      begin
        if (!WRITE && !USER_MODE)
          access_ok = 1'b0;
        else if (USER_MODE && !user_enable)
          access_ok = 1'b0;
      end
      default:
        access_ok = !USER_MODE || user_enable;
    endcase
  end

  assign do_write = REQ && WRITE && access_ok;
  assign sel_valid = counter_selector < 6'(NUM_CNT);
  assign sel_index = counter_selector[2:0];
  assign swinc_bits = (do_write && reg_id == perf_monitor_pkg::REG_SW_INCREMENT) ?
                      WDATA[NUM_CNT-1:0] : '0;

  // Event counters, one per generate slice
  for (genvar i = 0; i < NUM_CNT; i++)
  begin : g_counter
    logic [31:0] next_count;
    logic [7:0] next_type;
    logic inc;
    logic targeted;
    always_comb
    begin
      targeted = sel_valid && sel_index == 3'(i);
      inc = 1'b0;
      if (global_enable)
      begin
        if (event_type_select[i] == perf_monitor_pkg::EV_SW_INCREMENT)
          inc = swinc_bits[i];
        else
          inc = event_hit(event_type_select[i], EVENTS);
      end
      // An event reset or a write of this counter beats the increment, so no wrap is flagged then
      wrap[i] = 1'b0;
      next_count = event_count[i];
      if (do_write && reg_id == perf_monitor_pkg::REG_CONTROL &&
          WDATA[perf_monitor_pkg::CTRL_EVENT_RESET_BIT])
        next_count = perf_monitor_pkg::ZERO_WORD;
      else if (do_write && reg_id == perf_monitor_pkg::REG_EVENT_COUNT && targeted)
        next_count = WDATA;
      else if (inc)
      begin
        wrap[i] = &event_count[i];
        next_count = event_count[i] + 32'h00000001;
      end
      next_type = event_type_select[i];
      if (do_write && reg_id == perf_monitor_pkg::REG_EVENT_TYPE && targeted)
        next_type = WDATA[7:0];
    end
    always_ff @(posedge CLK)
    begin
      if (!RST_N)
      begin
        event_count[i] <= perf_monitor_pkg::ZERO_WORD;
        event_type_select[i] <= perf_monitor_pkg::EVENT_TYPE_RESET;
      end
      else
      begin
        event_count[i] <= next_count;
        event_type_select[i] <= next_type;
      end
    end
  end

  // Cycle counter and control state
  always_comb
  begin
    cycle_wrap = 1'b0;
    next_cycle_tally_value = cycle_tally_value;
    if (do_write && reg_id == perf_monitor_pkg::REG_CONTROL &&
        WDATA[perf_monitor_pkg::CTRL_CYCLE_RESET_BIT])
      next_cycle_tally_value = perf_monitor_pkg::ZERO_WORD;
    // Writing while enabled is the caller's hazard; the write simply wins
    else if (do_write && reg_id == perf_monitor_pkg::REG_CYCLE)
      next_cycle_tally_value = WDATA;
    else if (global_enable)
    begin
      cycle_wrap = &cycle_tally_value;
      next_cycle_tally_value = cycle_tally_value + 32'h00000001;
    end
    next_global_enable = global_enable;
    if (do_write && reg_id == perf_monitor_pkg::REG_CONTROL)
      next_global_enable = WDATA[perf_monitor_pkg::CTRL_ENABLE_BIT];
    next_user_enable = user_enable;
    if (do_write && reg_id == perf_monitor_pkg::REG_USER_ACCESS)
      next_user_enable = WDATA[perf_monitor_pkg::USER_ENABLE_BIT];
    next_counter_selector = counter_selector;
    if (do_write && reg_id == perf_monitor_pkg::REG_SELECT)
      next_counter_selector = WDATA[5:0];
    next_irq_enable = irq_enable;
    if (do_write && reg_id == perf_monitor_pkg::REG_IRQ_SET)
      next_irq_enable = irq_enable | (WDATA & perf_monitor_pkg::FLAG_MASK);
    else if (do_write && reg_id == perf_monitor_pkg::REG_IRQ_CLEAR)
      next_irq_enable = irq_enable & ~WDATA;
    // Clear first, then set, so a wrap in the clearing cycle survives
    next_overflow_flags = overflow_flags;
    if (do_write && reg_id == perf_monitor_pkg::REG_OVERFLOW)
      next_overflow_flags = overflow_flags & ~WDATA;
    next_overflow_flags[NUM_CNT-1:0] = next_overflow_flags[NUM_CNT-1:0] | wrap;
    next_overflow_flags[perf_monitor_pkg::CYCLE_FLAG_BIT] =
      next_overflow_flags[perf_monitor_pkg::CYCLE_FLAG_BIT] | cycle_wrap;
    next_overflow_flags = next_overflow_flags & perf_monitor_pkg::FLAG_MASK;
    next_irq_n = ~|(overflow_flags & irq_enable);
  end

  // Answer path
  always_comb
  begin
    next_ack = REQ;
    next_undef = REQ && !access_ok;
    next_rdata = perf_monitor_pkg::ZERO_WORD;
    if (REQ && !WRITE && access_ok)
    begin
      unique case (reg_id)
        perf_monitor_pkg::REG_CONTROL:
          next_rdata = {31'h00000000, global_enable} & perf_monitor_pkg::CTRL_READ_MASK;
        perf_monitor_pkg::REG_OVERFLOW:
          next_rdata = overflow_flags;
        perf_monitor_pkg::REG_SELECT:
          next_rdata = {26'h0000000, counter_selector};
        perf_monitor_pkg::REG_CYCLE:
          next_rdata = cycle_tally_value;
        perf_monitor_pkg::REG_EVENT_TYPE:
          if (sel_valid)
            next_rdata = {24'h000000, event_type_select[sel_index]};
        perf_monitor_pkg::REG_EVENT_COUNT:
          if (sel_valid)
            next_rdata = event_count[sel_index];
        perf_monitor_pkg::REG_USER_ACCESS:
          next_rdata = {31'h00000000, user_enable};
        perf_monitor_pkg::REG_IRQ_SET, perf_monitor_pkg::REG_IRQ_CLEAR:
          next_rdata = irq_enable;
        default:
          next_rdata = perf_monitor_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      global_enable <= 1'b0;
      user_enable <= 1'b0;
      counter_selector <= perf_monitor_pkg::SELECT_RESET;
      cycle_tally_value <= perf_monitor_pkg::ZERO_WORD;
      overflow_flags <= perf_monitor_pkg::ZERO_WORD;
      irq_enable <= perf_monitor_pkg::ZERO_WORD;
      ACK <= 1'b0;
      UNDEF <= 1'b0;
      RDATA <= perf_monitor_pkg::ZERO_WORD;
      IRQ_N <= 1'b1;
    end
    else
    begin
      global_enable <= next_global_enable;
      user_enable <= next_user_enable;
      counter_selector <= next_counter_selector;
      cycle_tally_value <= next_cycle_tally_value;
      overflow_flags <= next_overflow_flags;
      irq_enable <= next_irq_enable;
      ACK <= next_ack;
      UNDEF <= next_undef;
      RDATA <= next_rdata;
      IRQ_N <= next_irq_n;
    end
  end

endmodule // perf_monitor_counters

// File: dv/event_source.sv
// Purpose: Pipeline event source at the monitor's event inputs
// Assumes: Each high cycle of a bit is one event
// Notes: Lines rest low between pulses, as no event occurs then
`timescale 1ns/1ps
module event_source (
  // Clock
  input wire logic clk,
  // Event pulses, bit n for code n
  output logic [perf_monitor_pkg::NUM_EVENTS-1:0] events
);
  initial events = '0;
  // One count per high cycle of a code's bit
  task automatic pulse(input logic [perf_monitor_pkg::NUM_EVENTS-1:0] m, input int n);
    repeat (n)
    begin
      @(posedge clk);
      events <= m;
    end
    @(posedge clk);
    events <= '0;
  endtask
endmodule // event_source

// File: dv/perf_monitor_counters_props.sv
// Purpose: Port checks of the monitor register port
// Assumes: ACK one cycle after each request cycle
// Notes: Counter values are judged by the bench
`timescale 1ns/1ps
module perf_monitor_props #(
  parameter int NUM_CNT = 6
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic REQ,
  input wire logic WRITE,
  input wire logic [3:0] CRM,
  input wire logic [2:0] OPC2,
  input wire logic USER_MODE,
  input wire logic [31:0] WDATA,
  input wire logic ACK,
  input wire logic UNDEF,
  input wire logic [31:0] RDATA,
  // Events and interrupt
  input wire logic [perf_monitor_pkg::NUM_EVENTS-1:0] EVENTS,
  input wire logic IRQ_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic rd = REQ && !WRITE;
  wire logic gc = CRM == perf_monitor_pkg::CRM_CONTROL_GROUP;
  wire logic gd = CRM == perf_monitor_pkg::CRM_COUNT_GROUP;
  wire logic ge = CRM == perf_monitor_pkg::CRM_USER_GROUP;
  a_ack_after_req: assert property (REQ |=> ACK) else $error("no ack");
  a_quiet_idle: assert property (!REQ |=> !ACK && !UNDEF && RDATA == 32'h0)
    else $error("answer without request");
  a_undef_no_data: assert property (UNDEF |-> ACK && RDATA == 32'h0)
    else $error("refusal carries data");
  a_swinc_priv_read: assert property (rd && !USER_MODE && gc && OPC2 == 3'h4 |=> UNDEF)
    else $error("increment read accepted");
  a_priv_count_ok: assert property (REQ && !USER_MODE && gd && OPC2 <= 3'h2 |=> !UNDEF)
    else $error("privileged access refused");
  a_flag_reserved: assert property (rd && gc && OPC2 == 3'h3 |=>
    (RDATA & ~perf_monitor_pkg::FLAG_MASK) == 32'h0) else $error("flag bits");
  a_type_upper_zero: assert property (rd && gd && OPC2 == 3'h1 |=> RDATA[31:8] == 24'h0)
    else $error("type upper bits");
  a_sel_upper_zero: assert property (rd && gc && OPC2 == 3'h5 |=> RDATA[31:6] == 26'h0)
    else $error("select upper bits");
  a_user_irq_ctl: assert property (REQ && USER_MODE && ge && OPC2 inside {3'h1, 3'h2}
    |=> UNDEF) else $error("user irq access");
  c_refused: cover property (REQ ##1 UNDEF);
  c_irq: cover property ($fell(IRQ_N));
  c_swinc: cover property (REQ && WRITE && gc && OPC2 == 3'h4);
endmodule // perf_monitor_props
bind perf_monitor_counters perf_monitor_props #(.NUM_CNT(NUM_CNT)) i_props (.CLK(CLK),
  .RST_N(RST_N), .REQ(REQ), .WRITE(WRITE), .CRM(CRM), .OPC2(OPC2), .USER_MODE(USER_MODE),
  .WDATA(WDATA), .ACK(ACK), .UNDEF(UNDEF), .RDATA(RDATA), .EVENTS(EVENTS), .IRQ_N(IRQ_N));

// File: dv/perf_monitor_counters_tb.sv
// Purpose: Self-checking bench for the monitor counters
// Assumes: Answer one cycle after each request
// Notes: Table rows first, counting cases after
`timescale 1ns/1ps
module perf_monitor_counters_tb;
  typedef struct packed {
    logic w;
    logic [3:0] crm;
    logic [2:0] opc;
    logic u;
    logic [31:0] wd;
    logic [31:0] rd;
    logic ud;
  } row_t;
  localparam logic [3:0] GC = perf_monitor_pkg::CRM_CONTROL_GROUP;
  localparam logic [3:0] GD = perf_monitor_pkg::CRM_COUNT_GROUP;
  localparam logic [3:0] GE = perf_monitor_pkg::CRM_USER_GROUP;
  logic CLK, RST_N, REQ, WRITE, USER_MODE;
  logic [3:0] CRM;
  logic [2:0] OPC2;
  logic [31:0] WDATA, RDATA, rd_v, c0;
  logic ACK, UNDEF, IRQ_N, ud_v;
  logic [perf_monitor_pkg::NUM_EVENTS-1:0] EVENTS;
  int err_total, total_checks;
  row_t rows [13] = '{
    '{1'b1, GC, 3'h5, 1'b0, 32'h3, 32'h0, 1'b0},
    '{1'b0, GC, 3'h5, 1'b0, 32'h0, 32'h3, 1'b0},
    '{1'b1, GD, 3'h1, 1'b0, 32'h1AB, 32'h0, 1'b0},
    '{1'b0, GD, 3'h1, 1'b0, 32'h0, 32'hAB, 1'b0},
    '{1'b0, GC, 3'h4, 1'b0, 32'h0, 32'h0, 1'b1},
    '{1'b0, GC, 3'h5, 1'b1, 32'h0, 32'h0, 1'b1},
    '{1'b0, GC, 3'h1, 1'b0, 32'h0, 32'h0, 1'b1},
    '{1'b1, GE, 3'h0, 1'b0, 32'h1, 32'h0, 1'b0},
    '{1'b0, GC, 3'h5, 1'b1, 32'h0, 32'h3, 1'b0},
    '{1'b0, GC, 3'h4, 1'b1, 32'h0, 32'h0, 1'b0},
    '{1'b1, GE, 3'h0, 1'b1, 32'h0, 32'h0, 1'b1},
    '{1'b1, GE, 3'h1, 1'b1, 32'h1, 32'h0, 1'b1},
    '{1'b0, GE, 3'h0, 1'b1, 32'h0, 32'h1, 1'b0}
  };
  perf_monitor_counters #(.NUM_CNT(perf_monitor_pkg::NUM_COUNTERS)) i_dut (.CLK(CLK),
    .RST_N(RST_N), .REQ(REQ), .WRITE(WRITE), .CRM(CRM), .OPC2(OPC2), .USER_MODE(USER_MODE),
    .WDATA(WDATA), .ACK(ACK), .UNDEF(UNDEF), .RDATA(RDATA), .EVENTS(EVENTS), .IRQ_N(IRQ_N));
  event_source i_src (.clk(CLK), .events(EVENTS));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] c, input logic [2:0] o, input logic u,
    input logic [31:0] d);
    @(posedge CLK);
    REQ <= 1'b1;
    WRITE <= w;
    CRM <= c;
    OPC2 <= o;
    USER_MODE <= u;
    WDATA <= d;
    @(posedge CLK);
    REQ <= 1'b0;
    @(negedge CLK);
    cmp(32'(ACK), 32'h1);
    rd_v = RDATA;
    ud_v = UNDEF;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Whole run is well under 3000 cycles
  initial
  begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    {RST_N, REQ, WRITE, USER_MODE, CRM, OPC2, WDATA} = '0;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    cmp(32'(ACK), 32'h0);
    cmp(32'(UNDEF), 32'h0);
    cmp(32'(IRQ_N), 32'h1);
    cmp(RDATA, 32'h0);
    foreach (rows[i])
    begin
      acc(rows[i].w, rows[i].crm, rows[i].opc, rows[i].u, rows[i].wd);
      cmp(rd_v, rows[i].rd);
      cmp(32'(ud_v), 32'(rows[i].ud));
    end
    for (int k = 1; k <= 16; k++)
    begin
      acc(1'b1, GD, 3'h1, 1'b0, k);
      acc(1'b1, GC, 3'h0, 1'b0, 32'h3);
      i_src.pulse(17'h1 << k, 3);
      i_src.pulse(~(17'h1 << k), 1);
      acc(1'b0, GD, 3'h2, 1'b0, 32'h0);
      cmp(rd_v, (k == 8 || k == 14) ? 32'h0 : 32'h3);
    end
    acc(1'b1, GC, 3'h0, 1'b0, 32'h2);
    i_src.pulse(17'h1 << 16, 3);
    acc(1'b0, GD, 3'h2, 1'b0, 32'h0);
    cmp(rd_v, 32'h0);
    acc(1'b0, GD, 3'h0, 1'b0, 32'h0);
    c0 = rd_v;
    acc(1'b0, GD, 3'h0, 1'b0, 32'h0);
    cmp(rd_v, c0);
    acc(1'b1, GC, 3'h5, 1'b0, 32'h1);
    acc(1'b1, GD, 3'h1, 1'b0, 32'h0);
    acc(1'b1, GD, 3'h2, 1'b0, 32'hFFFFFFFF);
    acc(1'b1, GC, 3'h5, 1'b0, 32'h2);
    acc(1'b1, GD, 3'h1, 1'b0, 32'h4);
    acc(1'b1, GC, 3'h0, 1'b0, 32'h1);
    i_src.pulse('1, 2);
    acc(1'b1, GC, 3'h4, 1'b0, 32'h6);
    acc(1'b0, GD, 3'h2, 1'b0, 32'h0);
    cmp(rd_v, 32'h2);
    acc(1'b1, GC, 3'h5, 1'b0, 32'h1);
    acc(1'b0, GD, 3'h2, 1'b0, 32'h0);
    cmp(rd_v, 32'h0);
    acc(1'b0, GC, 3'h3, 1'b0, 32'h0);
    cmp(rd_v, 32'h2);
    // Cycle counter stopped before it is loaded
    acc(1'b1, GC, 3'h0, 1'b0, 32'h0);
    acc(1'b1, GD, 3'h0, 1'b0, 32'hFFFFFFF0);
    acc(1'b1, GC, 3'h0, 1'b0, 32'h1);
    acc(1'b1, GE, 3'h1, 1'b0, 32'h80000000);
    repeat (20) @(posedge CLK);
    acc(1'b0, GC, 3'h3, 1'b0, 32'h0);
    cmp(rd_v, 32'h80000002);
    cmp(32'(IRQ_N), 32'h0);
    acc(1'b1, GC, 3'h3, 1'b0, 32'h0);
    acc(1'b0, GC, 3'h3, 1'b0, 32'h0);
    cmp(rd_v, 32'h80000002);
    acc(1'b1, GC, 3'h3, 1'b0, 32'h80000002);
    acc(1'b0, GC, 3'h3, 1'b0, 32'h0);
    cmp(rd_v, 32'h0);
    cmp(32'(IRQ_N), 32'h1);
    // Mid-run reset drops selector and user enable back to zero
    acc(1'b1, GC, 3'h5, 1'b0, 32'h5);
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    cmp(32'(ACK), 32'h0);
    cmp(32'(IRQ_N), 32'h1);
    acc(1'b0, GC, 3'h5, 1'b0, 32'h0);
    cmp(rd_v, 32'h0);
    acc(1'b0, GE, 3'h0, 1'b0, 32'h0);
    cmp(rd_v, 32'h0);
    end_of_test();
  end
endmodule // perf_monitor_counters_tb
